//--- rtl/cmx_pkg.sv
// package for the current mux and conditioning register bank
// assumes a single 25 MHz system clock and synchronous reset
package cmx_pkg;
  localparam int CMX_DATA_W = 8;
  localparam int CMX_ADDR_W = 5;
  localparam logic [4:0] CMX_OFS_CHAN = 5'h06;
  localparam logic [4:0] CMX_OFS_COND = 5'h07;
  localparam logic [7:0] CMX_RST_CHAN = 8'h00;
  localparam logic [7:0] CMX_RST_COND = 8'h00;
  localparam int CMX_CHAN_LSB = 0;
  localparam int CMX_CHAN_W = 6;
  localparam int CMX_NUM_CHAN = 64;
  localparam int CMX_GAIN_LSB = 0;
  localparam int CMX_POLE1_LSB = 2;
  localparam int CMX_POLE2_LSB = 4;
  localparam int CMX_FOFF_BIT = 6;
  localparam int CMX_FE_DIS_BIT = 5;
  localparam int CMX_LVL_SEL_BIT = 7;
  localparam int CMX_LVL_W = 4;
  localparam logic [1:0] CMX_POLE_TEST = 2'h3;
  typedef enum logic [1:0] {cmx_gain_0p4, cmx_gain_2, cmx_gain_10, cmx_gain_hi} cmx_gain_e;
  typedef enum logic [1:0] {cmx_fc_400, cmx_fc_2k, cmx_fc_10k, cmx_fc_test} cmx_fc_e;
endpackage : cmx_pkg

//--- rtl/cmx_reg8.sv
// one 8-bit read/write register with reset value
// assumes write strobe and data from the same clock domain
module cmx_reg8
  import cmx_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);
  logic [7:0] next_q;

  always_comb begin
    next_q = q;
    if (wr_en) begin
      next_q = wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= RST_VAL;
    end else begin
      q <= next_q;
    end
  end
endmodule // cmx_reg8

//--- rtl/cmx_regs.sv
// current mux channel select and conditioning amplifier registers
// assumes bus strobes synchronous to clk_sys; function enable and level
// register bits arrive from sibling blocks on the same clock
//
// Behaviour
// - The current source goes to the channel whose number equals the channel field.
// - Bits 7 and 6 of the channel register are stored and read back only.
// - Reset clears both registers to zero.
// - Current flows only while the function enable disable bit 5 is clear.
// - Level bit 7 picks the ten-bit DAC, else the four-bit source at the level.
// - Filter-off clear enables the amplifier and drives the converter input pin.
// - Filter-off set floats the amplifier output so the pin is an input.
// - Gain codes 00, 01, 10 pick gains 0.4, 2 and 10; code 11 is the high gain.
// - Bits 3..2 set the first filter cutoff 400 Hz, 2 kHz or 10 kHz.
// - Bits 5..4 set the second filter cutoff 400 Hz, 2 kHz or 10 kHz.
// - Bit 7 of the conditioning register is stored and read back only.
// - The two cutoff fields act independently.
// - When level bit 7 does not pick the DAC it is a general-purpose DAC.
module cmx_regs
  import cmx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [CMX_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [CMX_DATA_W-1:0] reg_wdata,
  output logic [CMX_DATA_W-1:0] reg_rdata,
  output logic reg_rsel,
  input wire logic [7:0] func_enable,
  input wire logic [7:0] current_level,
  output logic [CMX_NUM_CHAN-1:0] chan_current_en,
  output logic [CMX_CHAN_W-1:0] chan_index,
  output logic four_bit_current_source_en,
  output logic [CMX_LVL_W-1:0] four_bit_current_source_level,
  output logic current_source_dac_select,
  output logic dac_general_purpose,
  output logic [1:0] amp_gain,
  output logic [1:0] pole1_cutoff,
  output logic [1:0] pole2_cutoff,
  output logic pole_test_mode,
  output logic amp_enable,
  output logic adc_in_o,
  output logic adc_in_oe
);
  logic [7:0] chan_q;
  logic [7:0] cond_q;
  logic wr_chan;
  logic wr_cond;
  logic hit_chan;
  logic hit_cond;
  logic [7:0] next_rdata;
  logic src_on;
  logic [CMX_NUM_CHAN-1:0] next_chan_en;

  // address decode
  always_comb begin
    hit_chan = 1'b0;
    hit_cond = 1'b0;
    if (reg_addr == CMX_OFS_CHAN) begin
      hit_chan = 1'b1;
    end else if (reg_addr == CMX_OFS_COND) begin
      hit_cond = 1'b1;
    end
  end

  assign wr_chan = reg_wr && hit_chan;
  assign wr_cond = reg_wr && hit_cond;
  assign reg_rsel = hit_chan || hit_cond;

  cmx_reg8 #(.RST_VAL(CMX_RST_CHAN)) u_chan (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_chan),
    .wr_data(reg_wdata),
    .q(chan_q)
  );

  cmx_reg8 #(.RST_VAL(CMX_RST_COND)) u_cond (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(wr_cond),
    .wr_data(reg_wdata),
    .q(cond_q)
  );

  // read data, unmapped reads as zero
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      if (hit_chan) begin
        next_rdata = chan_q;
      end else if (hit_cond) begin
        next_rdata = cond_q;
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  // source routing
  always_comb begin
    src_on = !func_enable[CMX_FE_DIS_BIT];
    next_chan_en = '0;
    if (src_on) begin
      next_chan_en[chan_q[CMX_CHAN_LSB +: CMX_CHAN_W]] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      chan_current_en <= '0;
      four_bit_current_source_en <= 1'b0;
      current_source_dac_select <= 1'b0;
      four_bit_current_source_level <= '0;
      dac_general_purpose <= 1'b1;
    end else begin
      reg_rdata <= next_rdata;
      chan_current_en <= next_chan_en;
      four_bit_current_source_en <= src_on && !current_level[CMX_LVL_SEL_BIT];
      current_source_dac_select <= src_on && current_level[CMX_LVL_SEL_BIT];
      four_bit_current_source_level <= current_level[CMX_LVL_W-1:0];
      dac_general_purpose <= !current_level[CMX_LVL_SEL_BIT];
    end
  end

  assign chan_index = chan_q[CMX_CHAN_LSB +: CMX_CHAN_W];
  assign amp_gain = cond_q[CMX_GAIN_LSB +: 2];
  assign pole1_cutoff = cond_q[CMX_POLE1_LSB +: 2];
  assign pole2_cutoff = cond_q[CMX_POLE2_LSB +: 2];
  // flags a host slip into the factory test code
  assign pole_test_mode = (pole1_cutoff == CMX_POLE_TEST) || (pole2_cutoff == CMX_POLE_TEST);
  assign amp_enable = !cond_q[CMX_FOFF_BIT];
  assign adc_in_oe = !cond_q[CMX_FOFF_BIT];
  assign adc_in_o = 1'b0;

  property p_chan_route;
    @(posedge clk_sys) disable iff (rst)
      !func_enable[CMX_FE_DIS_BIT] |=> chan_current_en[$past(chan_index)];
  endproperty
  a_chan_route: assert property (p_chan_route) else $error("channel not routed");

  property p_onehot;
    @(posedge clk_sys) disable iff (rst) $onehot0(chan_current_en);
  endproperty
  a_onehot: assert property (p_onehot) else $error("multiple channels");

  property p_store_hi;
    @(posedge clk_sys) disable iff (rst)
      wr_chan ##1 !reg_wr ##1 (reg_rd && hit_chan && !reg_wr) |=>
        reg_rdata[7:6] == $past(reg_wdata[7:6], 3);
  endproperty
  a_store_hi: assert property (p_store_hi) else $error("chan high bits lost");

  property p_reset;
    @(posedge clk_sys) rst |=> chan_q == 8'h00 && cond_q == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("reset not clear");

  property p_disable;
    @(posedge clk_sys) disable iff (rst)
      func_enable[CMX_FE_DIS_BIT] |=> chan_current_en == '0 && !four_bit_current_source_en
        && !current_source_dac_select;
  endproperty
  a_disable: assert property (p_disable) else $error("current while disabled");

  property p_src_sel;
    @(posedge clk_sys) disable iff (rst)
      !func_enable[CMX_FE_DIS_BIT] |=>
        current_source_dac_select == $past(current_level[CMX_LVL_SEL_BIT]);
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("source select wrong");

  property p_drive;
    @(posedge clk_sys) disable iff (rst)
      wr_cond && !reg_wdata[CMX_FOFF_BIT] |=> adc_in_oe && amp_enable;
  endproperty
  a_drive: assert property (p_drive) else $error("pin not driven");

  property p_float;
    @(posedge clk_sys) disable iff (rst)
      wr_cond && reg_wdata[CMX_FOFF_BIT] |=> !adc_in_oe;
  endproperty
  a_float: assert property (p_float) else $error("pin not released");

  property p_fields;
    @(posedge clk_sys) disable iff (rst)
      wr_cond |=> amp_gain == $past(reg_wdata[1:0]) && pole1_cutoff == $past(reg_wdata[3:2])
        && pole2_cutoff == $past(reg_wdata[5:4]) && cond_q[7] == $past(reg_wdata[7]);
  endproperty
  a_fields: assert property (p_fields) else $error("field mismatch");

  property p_gp_dac;
    @(posedge clk_sys) disable iff (rst)
      !current_level[CMX_LVL_SEL_BIT] |=> dac_general_purpose;
  endproperty
  a_gp_dac: assert property (p_gp_dac) else $error("dac not general purpose");

  property p_cond_rd;
    @(posedge clk_sys) disable iff (rst)
      wr_cond ##1 !reg_wr ##1 (reg_rd && hit_cond && !reg_wr) |=>
        reg_rdata[7] == $past(reg_wdata[7], 3);
  endproperty
  a_cond_rd: assert property (p_cond_rd) else $error("cond high bit lost");

  property p_level;
    @(posedge clk_sys) disable iff (rst)
      !func_enable[CMX_FE_DIS_BIT] && !current_level[CMX_LVL_SEL_BIT] |=>
        four_bit_current_source_en
        && four_bit_current_source_level == $past(current_level[CMX_LVL_W-1:0]);
  endproperty
  a_level: assert property (p_level) else $error("level source wrong");

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
      !wr_cond |=> $stable(pole1_cutoff) && $stable(pole2_cutoff) && $stable(amp_gain);
  endproperty
  a_hold: assert property (p_hold) else $error("field moved without write");

  c_route: cover property (@(posedge clk_sys) disable iff (rst) chan_current_en[63]);
  c_float: cover property (@(posedge clk_sys) disable iff (rst) !adc_in_oe);
  c_dac: cover property (@(posedge clk_sys) disable iff (rst) current_source_dac_select);
  c_gain_hi: cover property (@(posedge clk_sys) disable iff (rst) amp_gain == 2'h3);
endmodule // cmx_regs

//--- testbench/cmx_host.sv
// host model: drives register strobes of the bank one access at a time
// assumes strobes sampled on rising clk_sys, read data valid one cycle later
module cmx_host
  import cmx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [CMX_DATA_W-1:0] reg_rdata,
  output logic [CMX_ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [CMX_DATA_W-1:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = '0;
  end
  task automatic wr(input logic [CMX_ADDR_W-1:0] a, input logic [7:0] x);
    if (a == CMX_OFS_COND && x[3:2] == 2'h3) x[2] = 1'b0;
    if (a == CMX_OFS_COND && x[5:4] == 2'h3) x[4] = 1'b0;
    @(posedge clk_sys) #1;
    reg_addr = a;
    reg_wdata = x;
    reg_wr = 1'b1;
    @(posedge clk_sys) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~x;
  endtask
  task automatic rd(input logic [CMX_ADDR_W-1:0] a, output logic [7:0] x);
    @(posedge clk_sys) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    x = reg_rdata;
  endtask
  // zero the dac current: high byte (5'h0f) first, then low byte (5'h0e)
  task automatic dac_zero();
    wr(5'h0f, 8'h00);
    wr(5'h0e, 8'h00);
  endtask
endmodule // cmx_host

//--- testbench/current_mux_and_conditioning_regs_test.sv
// self-checking bench for the current mux and conditioning register bank
// assumes cmx_pkg, cmx_regs and the host model cmx_host are compiled first
module current_mux_and_conditioning_regs_test
  import cmx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, reg_wr, reg_rd;
  logic [CMX_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, func_enable, current_level, d, v, w;
  logic [63:0] chan_current_en;
  logic [5:0] chan_index;
  logic fbs_en, dac_sel, dac_gp, pole_test_mode, amp_enable, adc_in_oe;
  logic reg_rsel, rsel_q;
  logic [3:0] lvl;
  logic [1:0] amp_gain, pole1_cutoff, pole2_cutoff;
  int fails, compares, i;
  cmx_host cmx_host_i (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  cmx_regs cmx_regs_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rsel(reg_rsel),
    .func_enable(func_enable), .current_level(current_level),
    .chan_current_en(chan_current_en), .chan_index(chan_index),
    .four_bit_current_source_en(fbs_en), .four_bit_current_source_level(lvl),
    .current_source_dac_select(dac_sel), .dac_general_purpose(dac_gp),
    .amp_gain(amp_gain), .pole1_cutoff(pole1_cutoff), .pole2_cutoff(pole2_cutoff),
    .pole_test_mode(pole_test_mode), .amp_enable(amp_enable), .adc_in_o(),
    .adc_in_oe(adc_in_oe));
  function automatic logic [7:0] legal(input logic [7:0] x);
    if (x[3:2] == 2'h3) x[2] = 1'b0;
    if (x[5:4] == 2'h3) x[4] = 1'b0;
    return x;
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    compares++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task test_done();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // address hit as seen at the read edge
  always @(posedge clk_sys) begin
    if (reg_rd) rsel_q <= reg_rsel;
  end
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    func_enable = 8'h00;
    current_level = 8'h00;
    fails = 0;
    compares = 0;
    void'($urandom(11));
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    cmx_host_i.rd(CMX_OFS_CHAN, d);
    chk(d, 8'h00);
    cmx_host_i.rd(CMX_OFS_COND, d);
    chk(d, 8'h00);
    $display("reset value test done");
    for (i = 0; i < 48; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'hc0 : 8'($urandom);
      w = (i == 0) ? 8'hff : (i == 1) ? 8'h18 : 8'($urandom);
      func_enable = (i == 2) ? 8'h20 : 8'($urandom);
      current_level = 8'($urandom);
      cmx_host_i.wr(CMX_OFS_CHAN, v);
      cmx_host_i.rd(CMX_OFS_CHAN, d);
      chk(d, v);
      chk(rsel_q, 1'b1);
      chk(chan_index, v[5:0]);
      chk(chan_current_en, func_enable[5] ? 64'h0 : 64'h1 << v[5:0]);
      chk(fbs_en, !func_enable[5] && !current_level[7]);
      chk(dac_sel, !func_enable[5] && current_level[7]);
      chk(lvl, current_level[3:0]);
      chk(dac_gp, !current_level[7]);
      cmx_host_i.wr(CMX_OFS_COND, w);
      cmx_host_i.rd(CMX_OFS_COND, d);
      chk(rsel_q, 1'b1);
      w = legal(w);
      chk(d, w);
      chk(amp_gain, w[1:0]);
      chk(pole1_cutoff, w[3:2]);
      chk(pole2_cutoff, w[5:4]);
      chk(pole_test_mode, 1'b0);
      chk(amp_enable, !w[6]);
      chk(adc_in_oe, !w[6]);
    end
    $display("random register test done");
    current_level = 8'h80;
    cmx_host_i.dac_zero();
    cmx_host_i.rd(5'h0e, d);
    chk(d, 8'h00);
    chk(rsel_q, 1'b0);
    chk(dac_gp, 1'b0);
    chk(dac_sel, !func_enable[5]);
    cmx_host_i.rd(CMX_OFS_CHAN, d);
    chk(d, v);
    $display("unmapped access test done");
    @(posedge clk_sys) #1;
    rst = 1'b1;
    @(posedge clk_sys) #1;
    rst = 1'b0;
    cmx_host_i.rd(CMX_OFS_CHAN, d);
    chk(d, 8'h00);
    cmx_host_i.rd(CMX_OFS_COND, d);
    chk(d, 8'h00);
    chk(chan_current_en, func_enable[5] ? 64'h0 : 64'h1);
    chk(adc_in_oe, 1'b1);
    $display("second reset test done");
    test_done();
  end
endmodule // current_mux_and_conditioning_regs_test
